// ==== verilog/psimd_pkg.sv ====
// Overview of operation
// - four lane flags, one per byte, apart from ordinary condition flags
// - packed lane operations never touch negative, zero, carry, overflow
// - lane flags read and written through the status word register
// - all byte or halfword lanes computed at once, no carry between lanes
// - byte ops set each flag alone; non-saturating halfword ops set flag pairs
// - signed, unsigned and saturating add/sub; saturating clamps lanes
// - exchange forms swap halves of one operand, add one, subtract other
// - signed halfword add writes its flag into both bits of the pair
// - dual multiply: two signed 16x16 products, added or subtracted, +acc
// - long dual multiply accumulates into a 64-bit register pair
// - exchange option swaps halves of the second operand before multiply
// - overflow of a 32-bit dual multiply result sets sticky saturation flag; long forms never set it
// - sum of four byte absolute differences plus accumulator
// - pack one halfword from each source, second optionally shifted
// - unpack byte or halfword from any byte position, extend, maybe add
// - byte select takes first operand byte where lane flag is set
// - saturation flag stays set until software writes the status word
package psimd_pkg;

    // register byte addresses
    localparam logic [7:0] PSIMD_ADDR_OPA  = 8'h00;
    localparam logic [7:0] PSIMD_ADDR_OPB  = 8'h04;
    localparam logic [7:0] PSIMD_ADDR_ACCL = 8'h08;
    localparam logic [7:0] PSIMD_ADDR_ACCH = 8'h0c;
    localparam logic [7:0] PSIMD_ADDR_CTRL = 8'h10;
    localparam logic [7:0] PSIMD_ADDR_RESL = 8'h14;
    localparam logic [7:0] PSIMD_ADDR_RESH = 8'h18;
    localparam logic [7:0] PSIMD_ADDR_PSW  = 8'h1c;

    // control word fields
    localparam int PSIMD_CTRL_OP_LSB  = 0;
    localparam int PSIMD_CTRL_XCHG    = 8;
    localparam int PSIMD_CTRL_SEXT    = 9;
    localparam int PSIMD_CTRL_ADD     = 10;
    localparam int PSIMD_CTRL_ROT_LSB = 12;
    localparam int PSIMD_CTRL_SH_LSB  = 16;

    // status word fields
    localparam int PSIMD_PSW_NZCV_LSB = 28;
    localparam int PSIMD_PSW_SAT      = 27;
    localparam int PSIMD_PSW_GE_LSB   = 16;

    localparam logic [31:0] PSIMD_RST_WORD = 32'h0000_0000;

    typedef enum logic [4:0] {
        PSIMD_SIGNED_BYTE_ADD     = 5'h00,
        PSIMD_UNSIGNED_BYTE_ADD   = 5'h01,
        PSIMD_SIGNED_BYTE_SUB     = 5'h02,
        PSIMD_UNSIGNED_BYTE_SUB   = 5'h03,
        PSIMD_SIGNED_HALF_ADD     = 5'h04,
        PSIMD_UNSIGNED_HALF_ADD   = 5'h05,
        PSIMD_SIGNED_HALF_SUB     = 5'h06,
        PSIMD_UNSIGNED_HALF_SUB   = 5'h07,
        PSIMD_SAT_HALF_ADD        = 5'h08,
        PSIMD_UNSIGNED_EXCH_ADDSUB = 5'h09,
        PSIMD_UNSIGNED_EXCH_SUBADD = 5'h0a,
        PSIMD_SIGNED_EXCH_ADDSUB  = 5'h0b,
        PSIMD_SIGNED_EXCH_SUBADD  = 5'h0c,
        PSIMD_SAT_EXCH_ADDSUB     = 5'h0d,
        PSIMD_SAT_EXCH_SUBADD     = 5'h0e,
        PSIMD_DUAL_MUL_ADD        = 5'h0f,
        PSIMD_DUAL_MUL_SUB        = 5'h10,
        PSIMD_DUAL_MUL_ADD_ACC    = 5'h11,
        PSIMD_DUAL_MUL_SUB_ACC    = 5'h12,
        PSIMD_DUAL_MUL_ADD_LONG   = 5'h13,
        PSIMD_DUAL_MUL_SUB_LONG   = 5'h14,
        PSIMD_BYTE_ABS_DIFF_SUM_ACC = 5'h15,
        PSIMD_PACK_BOTTOM_TOP     = 5'h16,
        PSIMD_PACK_TOP_BOTTOM     = 5'h17,
        PSIMD_EXTEND_BYTE         = 5'h18,
        PSIMD_EXTEND_HALF         = 5'h19,
        PSIMD_BYTE_SELECT         = 5'h1a
    } psimd_op_e;

endpackage

// ==== verilog/psimd_lane_addsub.sv ====
`timescale 1ns/1ps
module psimd_lane_addsub (
    input  wire logic [31:0] a,
    input  wire logic [31:0] b,
    input  wire logic        half,
    input  wire logic        sgn,
    input  wire logic        sat,
    input  wire logic        sub_hi,
    input  wire logic        sub_lo,
    output logic      [31:0] res,
    output logic      [3:0]  ge
);
    logic [8:0]  bsum [4];
    logic [16:0] hsum [2];
    logic [15:0] hres [2];

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_byte
            logic [8:0] ea;
            logic [8:0] eb;
            assign ea = {sgn & a[8*i+7], a[8*i +: 8]};
            assign eb = {sgn & b[8*i+7], b[8*i +: 8]};
            assign bsum[i] = sub_lo ? ea - eb : ea + eb;
        end
        for (i = 0; i < 2; i++) begin : g_half
            logic [16:0] ea;
            logic [16:0] eb;
            logic        sb;
            assign ea = {sgn & a[16*i+15], a[16*i +: 16]};
            assign eb = {sgn & b[16*i+15], b[16*i +: 16]};
            assign sb = (i == 1) ? sub_hi : sub_lo;
            assign hsum[i] = sb ? ea - eb : ea + eb;
            always_comb begin
                if (sat && hsum[i][16] != hsum[i][15]) begin
                    hres[i] = hsum[i][16] ? 16'h8000 : 16'h7fff;
                end else begin
                    hres[i] = hsum[i][15:0];
                end
            end
        end
    endgenerate

    function automatic logic lane_flag(input logic top, input logic s,
                                       input logic d);
        lane_flag = (s | d) ? ~top : top;
    endfunction

    always_comb begin
        if (half) begin
            res = {hres[1], hres[0]};
            ge = {{2{lane_flag(hsum[1][16], sgn, sub_hi)}},
                  {2{lane_flag(hsum[0][16], sgn, sub_lo)}}};
        end else begin
            res = {bsum[3][7:0], bsum[2][7:0], bsum[1][7:0], bsum[0][7:0]};
            ge = {lane_flag(bsum[3][8], sgn, sub_lo),
                  lane_flag(bsum[2][8], sgn, sub_lo),
                  lane_flag(bsum[1][8], sgn, sub_lo),
                  lane_flag(bsum[0][8], sgn, sub_lo)};
        end
    end
endmodule

// ==== verilog/psimd_alu.sv ====
`timescale 1ns/1ps
module psimd_alu (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [3:0]  lane_ge_flags,
    output logic             sat_flag
);
    logic [31:0] opa_q, opa_d;
    logic [31:0] opb_q, opb_d;
    logic [31:0] accl_q, accl_d;
    logic [31:0] acch_q, acch_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] resl_q, resl_d;
    logic [31:0] resh_q, resh_d;
    logic [3:0]  nzcv_q, nzcv_d;
    logic        sat_q, sat_d;
    logic [3:0]  ge_q, ge_d;
    logic [31:0] prdata_q, prdata_d;

    logic        wr_acc;
    logic        setup_rd;
    logic        mapped;
    logic        ro_hit;

    // decoded command from the control write
    psimd_pkg::psimd_op_e op;
    logic        xchg;
    logic        sext;
    logic        addin;
    logic [1:0]  rot;
    logic [4:0]  shamt;

    // lane adder hookup
    logic [31:0] bx;
    logic        as_half;
    logic        as_sgn;
    logic        as_sat;
    logic        as_sub_hi;
    logic        as_sub_lo;
    logic [31:0] as_res;
    logic [3:0]  as_ge;
    logic        is_addsub;

    // multiply, abs diff, pack, unpack
    logic signed [31:0] prod_hi;
    logic signed [31:0] prod_lo;
    logic signed [33:0] dual;
    logic signed [33:0] dual_acc;
    logic        [63:0] dual_long;
    logic        [31:0] sad;
    logic        [31:0] rotb;
    logic        [31:0] ext;
    logic        [31:0] shl_b;
    logic        [31:0] asr_b;
    logic        [31:0] sel_res;

    logic [31:0] op_res_lo;
    logic [31:0] op_res_hi;
    logic        op_ge_we;
    logic        op_sat_set;

    function automatic logic [31:0] swap_halves(input logic [31:0] v);
        swap_halves = {v[15:0], v[31:16]};
    endfunction

    function automatic logic [31:0] sext16(input logic [15:0] v);
        sext16 = {{16{v[15]}}, v};
    endfunction

    function automatic logic [8:0] abs_diff(input logic [7:0] x,
                                            input logic [7:0] y);
        abs_diff = (x >= y) ? {1'b0, x - y} : {1'b0, y - x};
    endfunction

    assign wr_acc   = psel & penable & pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;

    always_comb begin
        case (paddr)
            psimd_pkg::PSIMD_ADDR_OPA,
            psimd_pkg::PSIMD_ADDR_OPB,
            psimd_pkg::PSIMD_ADDR_ACCL,
            psimd_pkg::PSIMD_ADDR_ACCH,
            psimd_pkg::PSIMD_ADDR_CTRL,
            psimd_pkg::PSIMD_ADDR_PSW: begin
                mapped = 1'b1;
                ro_hit = 1'b0;
            end
            psimd_pkg::PSIMD_ADDR_RESL,
            psimd_pkg::PSIMD_ADDR_RESH: begin
                mapped = 1'b1;
                ro_hit = 1'b1;
            end
            default: begin
                mapped = 1'b0;
                ro_hit = 1'b0;
            end
        endcase
    end

    // no wait states; unmapped accesses and result writes answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (~mapped | (pwrite & ro_hit));
    assign prdata  = prdata_q;

    // command fields come straight from the write data so that the
    // operation runs in the same edge as the control write
    assign op    = psimd_pkg::psimd_op_e'(
                       pwdata[psimd_pkg::PSIMD_CTRL_OP_LSB +: 5]);
    assign xchg  = pwdata[psimd_pkg::PSIMD_CTRL_XCHG];
    assign sext  = pwdata[psimd_pkg::PSIMD_CTRL_SEXT];
    assign addin = pwdata[psimd_pkg::PSIMD_CTRL_ADD];
    assign rot   = pwdata[psimd_pkg::PSIMD_CTRL_ROT_LSB +: 2];
    assign shamt = pwdata[psimd_pkg::PSIMD_CTRL_SH_LSB +: 5];

    // lane adder setup per command
    always_comb begin
        bx        = opb_q;
        as_half   = 1'b1;
        as_sgn    = 1'b0;
        as_sat    = 1'b0;
        as_sub_hi = 1'b0;
        as_sub_lo = 1'b0;
        is_addsub = 1'b1;
        case (op)
            psimd_pkg::PSIMD_SIGNED_BYTE_ADD: begin
                as_half = 1'b0;
                as_sgn  = 1'b1;
            end
            psimd_pkg::PSIMD_UNSIGNED_BYTE_ADD: begin
                as_half = 1'b0;
            end
            psimd_pkg::PSIMD_SIGNED_BYTE_SUB: begin
                as_half   = 1'b0;
                as_sgn    = 1'b1;
                as_sub_lo = 1'b1;
            end
            psimd_pkg::PSIMD_UNSIGNED_BYTE_SUB: begin
                as_half   = 1'b0;
                as_sub_lo = 1'b1;
            end
            psimd_pkg::PSIMD_SIGNED_HALF_ADD: begin
                as_sgn = 1'b1;
            end
            psimd_pkg::PSIMD_UNSIGNED_HALF_ADD: begin
                as_sgn = 1'b0;
            end
            psimd_pkg::PSIMD_SIGNED_HALF_SUB: begin
                as_sgn    = 1'b1;
                as_sub_hi = 1'b1;
                as_sub_lo = 1'b1;
            end
            psimd_pkg::PSIMD_UNSIGNED_HALF_SUB: begin
                as_sub_hi = 1'b1;
                as_sub_lo = 1'b1;
            end
            psimd_pkg::PSIMD_SAT_HALF_ADD: begin
                as_sgn = 1'b1;
                as_sat = 1'b1;
            end
            psimd_pkg::PSIMD_UNSIGNED_EXCH_ADDSUB: begin
                bx        = swap_halves(opb_q);
                as_sub_lo = 1'b1;
            end
            psimd_pkg::PSIMD_UNSIGNED_EXCH_SUBADD: begin
                bx        = swap_halves(opb_q);
                as_sub_hi = 1'b1;
            end
            psimd_pkg::PSIMD_SIGNED_EXCH_ADDSUB: begin
                bx        = swap_halves(opb_q);
                as_sgn    = 1'b1;
                as_sub_lo = 1'b1;
            end
            psimd_pkg::PSIMD_SIGNED_EXCH_SUBADD: begin
                bx        = swap_halves(opb_q);
                as_sgn    = 1'b1;
                as_sub_hi = 1'b1;
            end
            psimd_pkg::PSIMD_SAT_EXCH_ADDSUB: begin
                bx        = swap_halves(opb_q);
                as_sgn    = 1'b1;
                as_sat    = 1'b1;
                as_sub_lo = 1'b1;
            end
            psimd_pkg::PSIMD_SAT_EXCH_SUBADD: begin
                bx        = swap_halves(opb_q);
                as_sgn    = 1'b1;
                as_sat    = 1'b1;
                as_sub_hi = 1'b1;
            end
            default: begin
                bx        = xchg ? swap_halves(opb_q) : opb_q;
                is_addsub = 1'b0;
            end
        endcase
    end

    psimd_lane_addsub u_lanes (
        .a      (opa_q),
        .b      (bx),
        .half   (as_half),
        .sgn    (as_sgn),
        .sat    (as_sat),
        .sub_hi (as_sub_hi),
        .sub_lo (as_sub_lo),
        .res    (as_res),
        .ge     (as_ge)
    );

    assign prod_hi = $signed(opa_q[31:16]) * $signed(bx[31:16]);
    assign prod_lo = $signed(opa_q[15:0]) * $signed(bx[15:0]);

    always_comb begin
        if (op == psimd_pkg::PSIMD_DUAL_MUL_SUB ||
            op == psimd_pkg::PSIMD_DUAL_MUL_SUB_ACC ||
            op == psimd_pkg::PSIMD_DUAL_MUL_SUB_LONG) begin
            dual = 34'(prod_hi) - 34'(prod_lo);
        end else begin
            dual = 34'(prod_hi) + 34'(prod_lo);
        end
        dual_acc  = dual + 34'($signed(accl_q));
        dual_long = {acch_q, accl_q} + 64'($signed(dual));
    end

    assign sad = accl_q + 32'(abs_diff(opa_q[7:0], opb_q[7:0]))
               + 32'(abs_diff(opa_q[15:8], opb_q[15:8]))
               + 32'(abs_diff(opa_q[23:16], opb_q[23:16]))
               + 32'(abs_diff(opa_q[31:24], opb_q[31:24]));

    assign rotb = (opb_q >> {rot, 3'h0}) | (opb_q << (6'h20 - {rot, 3'h0}));

    always_comb begin
        if (op == psimd_pkg::PSIMD_EXTEND_BYTE) begin
            ext = sext ? {{24{rotb[7]}}, rotb[7:0]} : {24'h0, rotb[7:0]};
        end else begin
            ext = sext ? sext16(rotb[15:0]) : {16'h0, rotb[15:0]};
        end
        if (addin) begin
            ext = ext + opa_q;
        end
    end

    assign shl_b = opb_q << shamt;
    assign asr_b = 32'($signed(opb_q) >>> shamt);

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sel
            assign sel_res[8*g +: 8] = ge_q[g] ? opa_q[8*g +: 8]
                                               : opb_q[8*g +: 8];
        end
    endgenerate

    // result and flag effects of one command
    always_comb begin
        op_res_lo  = resl_q;
        op_res_hi  = resh_q;
        op_ge_we   = 1'b0;
        op_sat_set = 1'b0;
        if (is_addsub) begin
            op_res_lo = as_res;
            op_ge_we  = ~as_sat;
        end else begin
            case (op)
                psimd_pkg::PSIMD_DUAL_MUL_ADD,
                psimd_pkg::PSIMD_DUAL_MUL_SUB: begin
                    op_res_lo  = dual[31:0];
                    op_sat_set = dual[32] != dual[31];
                end
                psimd_pkg::PSIMD_DUAL_MUL_ADD_ACC,
                psimd_pkg::PSIMD_DUAL_MUL_SUB_ACC: begin
                    op_res_lo  = dual_acc[31:0];
                    op_sat_set = (dual_acc[33] != dual_acc[31]) ||
                                 (dual_acc[32] != dual_acc[31]);
                end
                psimd_pkg::PSIMD_DUAL_MUL_ADD_LONG,
                psimd_pkg::PSIMD_DUAL_MUL_SUB_LONG: begin
                    op_res_lo = dual_long[31:0];
                    op_res_hi = dual_long[63:32];
                end
                psimd_pkg::PSIMD_BYTE_ABS_DIFF_SUM_ACC: begin
                    op_res_lo = sad;
                end
                psimd_pkg::PSIMD_PACK_BOTTOM_TOP: begin
                    op_res_lo = {shl_b[31:16], opa_q[15:0]};
                end
                psimd_pkg::PSIMD_PACK_TOP_BOTTOM: begin
                    op_res_lo = {opa_q[31:16], asr_b[15:0]};
                end
                psimd_pkg::PSIMD_EXTEND_BYTE,
                psimd_pkg::PSIMD_EXTEND_HALF: begin
                    op_res_lo = ext;
                end
                psimd_pkg::PSIMD_BYTE_SELECT: begin
                    op_res_lo = sel_res;
                end
                default: begin
                    op_res_lo = resl_q;
                end
            endcase
        end
    end

    // register file next state
    always_comb begin
        opa_d    = opa_q;
        opb_d    = opb_q;
        accl_d   = accl_q;
        acch_d   = acch_q;
        ctrl_d   = ctrl_q;
        resl_d   = resl_q;
        resh_d   = resh_q;
        nzcv_d   = nzcv_q;
        sat_d    = sat_q;
        ge_d     = ge_q;
        prdata_d = prdata_q;
        if (wr_acc) begin
            case (paddr)
                psimd_pkg::PSIMD_ADDR_OPA:  opa_d  = pwdata;
                psimd_pkg::PSIMD_ADDR_OPB:  opb_d  = pwdata;
                psimd_pkg::PSIMD_ADDR_ACCL: accl_d = pwdata;
                psimd_pkg::PSIMD_ADDR_ACCH: acch_d = pwdata;
                psimd_pkg::PSIMD_ADDR_CTRL: begin
                    ctrl_d = pwdata;
                    resl_d = op_res_lo;
                    resh_d = op_res_hi;
                    if (op_ge_we) begin
                        ge_d = as_ge;
                    end
                    sat_d = sat_q | op_sat_set;
                end
                psimd_pkg::PSIMD_ADDR_PSW: begin
                    nzcv_d = pwdata[psimd_pkg::PSIMD_PSW_NZCV_LSB +: 4];
                    ge_d   = pwdata[psimd_pkg::PSIMD_PSW_GE_LSB +: 4];
                    sat_d  = pwdata[psimd_pkg::PSIMD_PSW_SAT];
                end
                default: begin
                    opa_d = opa_q;
                end
            endcase
        end
        if (setup_rd) begin
            case (paddr)
                psimd_pkg::PSIMD_ADDR_OPA:  prdata_d = opa_q;
                psimd_pkg::PSIMD_ADDR_OPB:  prdata_d = opb_q;
                psimd_pkg::PSIMD_ADDR_ACCL: prdata_d = accl_q;
                psimd_pkg::PSIMD_ADDR_ACCH: prdata_d = acch_q;
                psimd_pkg::PSIMD_ADDR_CTRL: prdata_d = ctrl_q;
                psimd_pkg::PSIMD_ADDR_RESL: prdata_d = resl_q;
                psimd_pkg::PSIMD_ADDR_RESH: prdata_d = resh_q;
                psimd_pkg::PSIMD_ADDR_PSW: begin
                    prdata_d = 32'h0;
                    prdata_d[psimd_pkg::PSIMD_PSW_NZCV_LSB +: 4] = nzcv_q;
                    prdata_d[psimd_pkg::PSIMD_PSW_SAT] = sat_q;
                    prdata_d[psimd_pkg::PSIMD_PSW_GE_LSB +: 4] = ge_q;
                end
                default: prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opa_q    <= psimd_pkg::PSIMD_RST_WORD;
            opb_q    <= psimd_pkg::PSIMD_RST_WORD;
            accl_q   <= psimd_pkg::PSIMD_RST_WORD;
            acch_q   <= psimd_pkg::PSIMD_RST_WORD;
            ctrl_q   <= psimd_pkg::PSIMD_RST_WORD;
            resl_q   <= psimd_pkg::PSIMD_RST_WORD;
            resh_q   <= psimd_pkg::PSIMD_RST_WORD;
            prdata_q <= psimd_pkg::PSIMD_RST_WORD;
            nzcv_q   <= 4'h0;
            sat_q    <= 1'b0;
            ge_q     <= 4'h0;
        end else begin
            opa_q    <= opa_d;
            opb_q    <= opb_d;
            accl_q   <= accl_d;
            acch_q   <= acch_d;
            ctrl_q   <= ctrl_d;
            resl_q   <= resl_d;
            resh_q   <= resh_d;
            prdata_q <= prdata_d;
            nzcv_q   <= nzcv_d;
            sat_q    <= sat_d;
            ge_q     <= ge_d;
        end
    end

    assign lane_ge_flags = ge_q;
    assign sat_flag      = sat_q;
endmodule

// ==== dv/psimd_alu_monitor.sv ====
`timescale 1ns/1ps
module psimd_alu_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  lane_ge_flags,
    input wire logic        sat_flag
);
    wire logic       wr_w   = psel && penable && pwrite;
    wire logic       wr_ctl = wr_w && paddr == psimd_pkg::PSIMD_ADDR_CTRL;
    wire logic       wr_psw = wr_w && paddr == psimd_pkg::PSIMD_ADDR_PSW;
    wire logic [4:0] op_w   = pwdata[4:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // prdata is loaded at the setup edge, so flags seen there must match
    sequence s_psw_read;
        psel && !penable && !pwrite && paddr == psimd_pkg::PSIMD_ADDR_PSW
        ##1 psel && penable;
    endsequence
    chk_flags_hold: assert property (!(wr_ctl || wr_psw) |=>
        $stable(lane_ge_flags)) else $error("lane flags moved");
    chk_sat_sticky: assert property (sat_flag && !wr_psw |=>
        sat_flag) else $error("sat flag dropped");
    chk_sat_cause: assert property (!sat_flag && !wr_ctl
        && !wr_psw |=> !sat_flag) else $error("sat flag rose alone");
    chk_psw_load: assert property (wr_psw |=>
        lane_ge_flags == $past(pwdata[19:16])
        && sat_flag == $past(pwdata[27])) else $error("status write lost");
    chk_psw_view: assert property (s_psw_read |->
        prdata[19:16] == lane_ge_flags && prdata[27] == sat_flag)
        else $error("status read wrong");
    chk_half_pairs: assert property (wr_ctl &&
        op_w inside {[5'h04:5'h07]} |=>
        lane_ge_flags[3] == lane_ge_flags[2]
        && lane_ge_flags[1] == lane_ge_flags[0]) else $error("pair split");
    chk_no_flag_op: assert property (wr_ctl && (op_w > 5'h0d
        || op_w == 5'h08) |=> $stable(lane_ge_flags))
        else $error("flags moved on non add op");
    chk_bad_addr: assert property (psel && penable && paddr > 8'h1c
        |-> pslverr && pready) else $error("unmapped access accepted");
endmodule
bind psimd_alu psimd_alu_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_ge_flags(lane_ge_flags), .sat_flag(sat_flag));

// ==== dv/psimd_apb_host.sv ====
`timescale 1ns/1ps
module psimd_apb_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic      [7:0]  paddr = 8'h00,
    output logic      [31:0] pwdata = 32'h0
);
    // request held until pready seen or 20 more edges pass; idle bus shows inverted address and data
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err,
        output logic hung);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge pclk);
        hung = pready !== 1'b1;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ==== dv/psimd_alu_bench.sv ====
`timescale 1ns/1ps
module psimd_alu_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        sat_flag, re, rh;
    logic [3:0]  lane_ge_flags;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rq;
    int          num_errors = 0;
    int          total_checks = 0;
    psimd_alu u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lane_ge_flags(lane_ge_flags), .sat_flag(sat_flag));
    psimd_apb_host u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic ee);
        u_host.xfer(wr, a, d, rq, re, rh);
        check("bus hang", {31'h0, rh}, 32'h0);
        if (rh) print_verdict();
        check("slave error", {31'h0, re}, {31'h0, ee});
    endtask
    // operands first, since the control write uses them as they stand
    task automatic op(input logic [31:0] c, a, b, ac, er, input logic [4:0] f);
        bus(1'b1, 8'h00, a, 1'b0);
        bus(1'b1, 8'h04, b, 1'b0);
        bus(1'b1, 8'h08, ac, 1'b0);
        bus(1'b1, 8'h10, c, 1'b0);
        bus(1'b0, 8'h14, 32'h0, 1'b0);
        check("result", rq, er);
        bus(1'b0, 8'h1c, 32'h0, 1'b0);
        check("status", rq, {4'ha, f[4], 7'h0, f[3:0], 16'h0});
        check("flag pins", {27'h0, sat_flag, lane_ge_flags}, {27'h0, f});
    endtask
    initial begin
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b0, 8'h1c, 32'h0, 1'b0);
        check("reset status", rq, 32'h0);
        bus(1'b1, 8'h1c, 32'ha0000000, 1'b0);
        op(32'h1,32'h80ff7f01,32'h80017f01,32'h0,32'hfe02,5'h0c);
        op(32'h0,32'h80ff7f01,32'h80017f01,32'h0,32'hfe02,5'h07);
        op(32'h3,32'h1020304,32'h2030102,32'h0,32'hffff0202,5'h03);
        op(32'h2,32'h80017f00,32'h1020001,32'h0,32'h7fff7fff,5'h02);
        op(32'h4,32'h80000001,32'h8000ffff,32'h0,32'h0,5'h03);
        op(32'h5,32'hffff0001,32'h20001,32'h0,32'h10002,5'h0c);
        op(32'h6,32'h1,32'h10000,32'h0,32'hffff0001,5'h03);
        op(32'h7,32'h20000,32'h10001,32'h0,32'h1ffff,5'h0c);
        op(32'h8,32'h7fff8000,32'hffff,32'h0,32'h7fff8000,5'h0c);
        op(32'h1a,32'h11223344,32'h55667788,32'h0,32'h11227788,5'h0c);
        op(32'h9,32'h50003,32'h20001,32'h0,32'h60001,5'h03);
        op(32'ha,32'h50003,32'h20001,32'h0,32'h40005,5'h0c);
        op(32'hb,32'hffff0005,32'h10000,32'h0,32'hffff0004,5'h03);
        op(32'hc,32'h30001,32'h50001,32'h0,32'h20006,5'h0f);
        op(32'hd,32'h7fff8000,32'h10001,32'h0,32'h7fff8000,5'h0f);
        op(32'he,32'h80007fff,32'h10001,32'h0,32'h80007fff,5'h0f);
        op(32'hf,32'h20003,32'h40005,32'h0,32'h17,5'h0f);
        op(32'h10f,32'h20003,32'h40005,32'h0,32'h16,5'h0f);
        op(32'h10,32'h20003,32'h40005,32'h0,32'hfffffff9,5'h0f);
        op(32'h11,32'h7fff7fff,32'h7fff7fff,32'h7fffffff,32'hfffe0001,5'h1f);
        op(32'h12,32'h20003,32'h40005,32'ha,32'h3,5'h1f);
        bus(1'b1, 8'h0c, 32'h1, 1'b0);
        op(32'h13,32'h20003,32'h40005,32'hffffffff,32'h16,5'h1f);
        bus(1'b0, 8'h18, 32'h0, 1'b0);
        check("long high", rq, 32'h2);
        op(32'h14,32'h20003,32'h40005,32'h0,32'hfffffff9,5'h1f);
        bus(1'b0, 8'h18, 32'h0, 1'b0);
        check("long high", rq, 32'h0);
        op(32'h15,32'ha0510ff,32'h50a1000,32'h100,32'h209,5'h1f);
        op(32'h40016,32'h1111aaaa,32'habc0000,32'h0,32'habc0aaaa,5'h1f);
        op(32'h40017,32'h1111aaaa,32'habc0,32'h0,32'h11110abc,5'h1f);
        op(32'h1218,32'h0,32'h80ff,32'h0,32'hffffff80,5'h1f);
        op(32'h419,32'h1,32'h12348000,32'h0,32'h8001,5'h1f);
        bus(1'b1, 8'h14, 32'h5, 1'b1);
        bus(1'b0, 8'h20, 32'h0, 1'b1);
        check("unmapped read", rq, 32'h0);
        bus(1'b1, 8'h1c, 32'ha0000000, 1'b0);
        bus(1'b0, 8'h1c, 32'h0, 1'b0);
        check("cleared status", rq, 32'ha0000000);
        bus(1'b0, 8'h14, 32'h0, 1'b0);
        check("result kept", rq, 32'h8001);
        print_verdict();
    end
endmodule
